// ==== hdl/sscs_pkg.sv ====
// package for the two-wire sensor control slave
// assumes a 200 MHz system clock; link clock comes from the bus master
package sscs_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [3:0] SLAVE_ADDR_HI = 4'hE;
   localparam logic [1:0] SLAVE_ADDR_LO = 2'h2;
   localparam logic [ADDR_W-1:0] REG_ADDR_RESET = 16'h0000;
   localparam int BITS_PER_BYTE = 8;
   localparam int MAX_BIT_RATE = 400000;
   localparam int SYS_CLK_HZ = 200000000;
   localparam int MIN_BIT_CYCLES = SYS_CLK_HZ / MAX_BIT_RATE;
   localparam int ACK_HOLD_NS = 300;
   localparam int SYS_CLK_NS = 5;
   localparam int ACK_HOLD_CYCLES = (ACK_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   typedef enum logic [2:0] {
      SSCS_IDLE,
      SSCS_DEV_ADDR,
      SSCS_REG_HI,
      SSCS_REG_LO,
      SSCS_WR_DATA,
      SSCS_RD_DATA,
      SSCS_RD_ACK
   } sscs_state_e;

   typedef struct packed {
      logic we;
      logic re;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sscs_reg_req_s;
endpackage

// ==== hdl/sscs_slave.sv ====
// two-wire serial control slave giving access to the sensor register space
// assumes open-drain lines resolved outside; register file answers rdata combinationally
`timescale 1ns/1ps
//
// Overview of operation
// R1 - eight bits MSB first, then one acknowledge
// R2 - lines only pulled low or released
// R3 - start seen anytime restarts, expects slave address
// R4 - data changes only while clock low
// R5 - answer only address 1110x10, x from pin
// R6 - eighth bit: one reads, zero writes
// R7 - acknowledge matching address after clock falls
// R8 - write gets two register address bytes, acked
// R9 - data bytes stored, acked, address increments
// R10 - read shifts out current register contents
// R11 - repeated start keeps loaded register address
// R12 - no acknowledge driven after read byte
// R13 - master ack continues read with next register
// R14 - master leaves last read byte unacked
// R15 - no master ack returns to idle
// R16 - register address kept across transactions
// R17 - address increments on clock rise of ack
// R18 - stop returns serial interface to idle
// R19 - link runs up to 400 kbit/s
// R20 - lines synchronised; edges and conditions from samples
module sscs_slave (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic link_clock_pin,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   input wire logic bus_address_select_pin,
   output sscs_pkg::sscs_reg_req_s reg_req,
   input wire logic [sscs_pkg::DATA_W-1:0] reg_rdata,
   output logic [sscs_pkg::ADDR_W-1:0] reg_addr,
   output logic busy
);
   import sscs_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // three-stage synchronisers
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic [2:0] sel_sync;
   logic scl;
   logic sda;
   logic sel;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         sel_sync <= 3'h0;
      end else begin
         scl_sync <= {scl_sync[1:0], link_clock_pin};  // [R19] [R20]
         sda_sync <= {sda_sync[1:0], serial_data_pin_in};
         sel_sync <= {sel_sync[1:0], bus_address_select_pin};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         scl <= 1'b1;
         sda <= 1'b1;
         sel <= 1'b0;
      end else begin
         if (scl_sync[1] == scl_sync[2]) begin
            scl <= scl_sync[2];
         end
         if (sda_sync[1] == sda_sync[2]) begin
            sda <= sda_sync[2];
         end
         if (sel_sync[1] == sel_sync[2]) begin
            sel <= sel_sync[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // edge and condition detection
   logic scl_d;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   assign scl_rise = scl & ~scl_d;
   assign scl_fall = ~scl & scl_d;
   assign start_cond = scl & scl_d & sda_d & ~sda;  // [R3] [R4]
   assign stop_cond = scl & scl_d & ~sda_d & sda;  // [R18] [R4]

   ////////////////////////////////////////////////////////////////////
   // protocol state
   sscs_state_e state;
   logic [3:0] bit_cnt;
   logic [DATA_W-1:0] shift;
   logic [DATA_W-1:0] rx_byte;
   logic [DATA_W-1:0] tx_byte;
   logic ack_phase;
   logic rd_mode;
   logic data_ack;
   logic ack_drive;
   logic byte_end;
   logic ack_rise;
   logic ack_end;
   logic addr_ok;
   logic next_oe;
   logic [ADDR_W-1:0] next_addr;

   function automatic logic addr_match(input logic [DATA_W-1:0] b, input logic x);
      addr_match = (b[7:4] == SLAVE_ADDR_HI) && (b[3] == x) && (b[2:1] == SLAVE_ADDR_LO);
   endfunction

   function automatic logic is_last_bit(input logic [3:0] cnt);
      is_last_bit = (cnt == 4'(BITS_PER_BYTE));
   endfunction

   // eighth bit taken: acknowledge slot opens on this clock fall
   assign byte_end = scl_fall && !ack_phase && is_last_bit(bit_cnt);
   // rise that begins the acknowledge bit, and the fall that ends it
   assign ack_rise = scl_rise && ack_phase;
   assign ack_end = scl_fall && ack_phase;
   assign rx_byte = shift;
   assign addr_ok = addr_match(rx_byte, sel);

   ////////////////////////////////////////////////////////////////////
   // bit counting and receive shifter
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         bit_cnt <= 4'h0;
      end else if (start_cond || stop_cond || state == SSCS_IDLE) begin
         bit_cnt <= 4'h0;
      end else if (ack_end) begin
         bit_cnt <= 4'h0;
      end else if (scl_rise && !ack_phase && !is_last_bit(bit_cnt)) begin
         bit_cnt <= bit_cnt + 4'h1;  // [R1]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         shift <= 8'h00;
      end else if (start_cond) begin
         shift <= 8'h00;
      end else if (scl_rise && !ack_phase && !is_last_bit(bit_cnt)) begin
         shift <= {shift[6:0], sda};  // [R1] [R4]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ack_phase <= 1'b0;
      end else if (start_cond || stop_cond) begin
         ack_phase <= 1'b0;
      end else if (byte_end) begin
         ack_phase <= 1'b1;
      end else if (ack_end) begin
         ack_phase <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transaction state
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= SSCS_IDLE;
      end else if (start_cond) begin
         state <= SSCS_DEV_ADDR;  // [R3] [R11]
      end else if (stop_cond) begin
         state <= SSCS_IDLE;  // [R18]
      end else if (byte_end) begin
         case (state)
            SSCS_DEV_ADDR: begin
               if (addr_ok) begin  // [R5]
                  state <= rx_byte[0] ? SSCS_RD_DATA : SSCS_REG_HI;  // [R6]
               end else begin
                  state <= SSCS_IDLE;
               end
            end
            SSCS_REG_HI: begin
               state <= SSCS_REG_LO;  // [R8]
            end
            SSCS_REG_LO: begin
               state <= SSCS_WR_DATA;
            end
            SSCS_WR_DATA: begin
               state <= SSCS_WR_DATA;  // [R9]
            end
            SSCS_RD_DATA: begin
               state <= SSCS_RD_ACK;  // [R12]
            end
            default: begin
               state <= SSCS_IDLE;
            end
         endcase
      end else if (ack_rise && state == SSCS_RD_ACK) begin
         // master ack low continues, high ends
         state <= sda ? SSCS_IDLE : SSCS_RD_DATA;  // [R13] [R15]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rd_mode <= 1'b0;
      end else if (start_cond) begin
         rd_mode <= 1'b0;
      end else if (byte_end && state == SSCS_DEV_ADDR && addr_ok) begin
         rd_mode <= rx_byte[0];  // [R6]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         data_ack <= 1'b0;
      end else if (start_cond || stop_cond) begin
         data_ack <= 1'b0;
      end else if (byte_end) begin
         data_ack <= state == SSCS_WR_DATA || state == SSCS_RD_DATA;
      end else if (ack_end) begin
         data_ack <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register address and register-file strobes
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_addr <= REG_ADDR_RESET;  // [R16]
      end else if (byte_end && state == SSCS_REG_HI) begin
         reg_addr <= {rx_byte, reg_addr[7:0]};  // [R8]
      end else if (byte_end && state == SSCS_REG_LO) begin
         reg_addr <= {reg_addr[15:8], rx_byte};
      end else if (ack_rise && data_ack) begin
         reg_addr <= next_addr;  // [R17] [R9] [R13]
      end
   end

   assign next_addr = reg_addr + 16'h0001;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_req <= '0;
      end else begin
         reg_req.we <= byte_end && state == SSCS_WR_DATA;  // [R9]
         reg_req.re <= ack_end && state == SSCS_RD_DATA && rd_mode;  // [R10]
         reg_req.addr <= reg_addr;
         reg_req.wdata <= rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // data line drive: pull low or release only
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         tx_byte <= 8'hFF;
      end else if (start_cond || stop_cond) begin
         tx_byte <= 8'hFF;
      end else if (ack_end && state == SSCS_RD_DATA) begin
         tx_byte <= reg_rdata;  // [R10] [R13] [R16]
      end else if (scl_fall && state == SSCS_RD_DATA && !ack_phase && !is_last_bit(bit_cnt)) begin
         tx_byte <= {tx_byte[6:0], 1'b1};  // [R1]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ack_drive <= 1'b0;
      end else if (start_cond || stop_cond) begin
         ack_drive <= 1'b0;
      end else if (byte_end) begin
         ack_drive <= (state == SSCS_DEV_ADDR && addr_ok) || state == SSCS_REG_HI
            || state == SSCS_REG_LO || state == SSCS_WR_DATA;  // [R7] [R8] [R9] [R12]
      end else if (ack_end) begin
         ack_drive <= 1'b0;
      end
   end

   always_comb begin
      next_oe = ack_drive;
      if (state == SSCS_RD_DATA && rd_mode && !ack_phase) begin
         next_oe = !tx_byte[7];  // [R10]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         serial_data_pin_oe <= 1'b0;
         serial_data_pin_out <= 1'b0;
         busy <= 1'b0;
      end else begin
         serial_data_pin_oe <= next_oe && !start_cond && !stop_cond;  // [R2] [R15]
         serial_data_pin_out <= 1'b0;  // [R2]
         busy <= state != SSCS_IDLE;
      end
   end
endmodule

// ==== testbench/sscs_slave_sva.sv ====
// checker for the two-wire control slave ports
// assumes it is bound into sscs_slave
`timescale 1ns/1ps
module sscs_sva (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic link_clock_pin,
   input wire logic serial_data_pin_in,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe,
   input wire sscs_pkg::sscs_reg_req_s reg_req,
   input wire logic [sscs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic busy
);
   import sscs_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_start;
      link_clock_pin[*2] ##0 $fell(serial_data_pin_in);
   endsequence
   sequence s_stop;
      link_clock_pin[*2] ##0 $rose(serial_data_pin_in);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////////////////
   a_out_low: assert property (!serial_data_pin_out)
      else $error("data out not low");
   a_reset_idle: assert property ($rose(reset_n) |-> !busy && !serial_data_pin_oe
      && reg_addr == 16'h0000) else $error("not idle after reset");
   a_we_pulse: assert property (reg_req.we |=> !reg_req.we)
      else $error("write strobe too long");
   a_re_pulse: assert property (reg_req.re |=> !reg_req.re)
      else $error("read strobe too long");
   a_oe_clk_low: assert property ($changed(serial_data_pin_oe) |-> !link_clock_pin)
      else $error("data changed while clock high");
   a_oe_busy: assert property (serial_data_pin_oe |-> busy || $past(busy))
      else $error("data pulled while idle");
   a_stop_idle: assert property (s_stop |-> ##[1:12] !busy)
      else $error("no idle after stop");
   a_start_busy: assert property (s_start |-> ##[1:12] busy)
      else $error("start not taken");
   a_addr_kept: assert property (!busy && !$past(busy) && !$past(busy, 2) |-> $stable(reg_addr))
      else $error("address moved while idle");
endmodule

// ==== testbench/sscs_master.sv ====
// bus master model: drives the link clock and pulls the data line
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module sscs_master (
   input wire logic data_line,
   output logic link_clk,
   output logic pull_low
);
   initial begin
      link_clk = 1'b1;
      pull_low = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic put_bit(input logic b, output logic r);
      pull_low = !b; // only while clock low
      #48 link_clk = 1'b1;
      #48 r = data_line;
      #48 link_clk = 1'b0;
      #24;
   endtask
   task automatic start_cond();
      pull_low = 1'b0;
      #48 link_clk = 1'b1;
      #48 pull_low = 1'b1;
      #48 link_clk = 1'b0;
      #24;
   endtask
   task automatic stop_cond();
      pull_low = 1'b1;
      #48 link_clk = 1'b1;
      #48 pull_low = 1'b0;
      #48;
   endtask
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(d[i], r[i]); // msb first
      put_bit(mack, ack);
   endtask
endmodule

// ==== testbench/tb_top.sv ====
// top bench: slave, master model and a register file stand-in
// assumes 200 MHz system clock; link steps of 48 ns
`timescale 1ns/1ps
module tb_top;
   import sscs_pkg::*;
   logic sys_clk, reset_n, sel, oe, dout, busy, clk_l, m_low, ack;
   wire data_line = !(m_low || oe); // pull-up when released
   sscs_reg_req_s req;
   logic [15:0] raddr, a;
   logic [7:0] rdata, rd;
   logic [23:0] expq[$];
   int num_errors = 0;
   int checks = 0;
   logic [31:0] seed = 32'h39061929;
   assign rdata = raddr[7:0] ^ 8'h5A;
   sscs_slave uut (.sys_clk(sys_clk), .reset_n(reset_n), .link_clock_pin(clk_l),
      .serial_data_pin_in(data_line), .serial_data_pin_out(dout), .serial_data_pin_oe(oe),
      .bus_address_select_pin(sel), .reg_req(req), .reg_rdata(rdata), .reg_addr(raddr),
      .busy(busy));
   sscs_master m (.data_line(data_line), .link_clk(clk_l), .pull_low(m_low));
   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] d, input logic exp_ack);
      m.xfer(d, 1'b1, rd, ack);
      chk("ack", ack, exp_ack);
   endtask
   task automatic rdb(input logic [7:0] exp, input logic mack);
      m.xfer(8'hFF, mack, rd, ack);
      chk("rdata", rd, exp);
      chk("no ack", ack, mack);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      if (req.we === 1'b1) begin
         chk("write", {req.addr, req.wdata}, expq.size() > 0 ? expq.pop_front() : ~{req.addr, req.wdata});
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
   initial begin
      reset_n = 1'b0;
      sel = 1'b0;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      a = 16'(rnd());
      m.start_cond();
      wr(8'hE4, 1'b0); // write
      wr(a[15:8], 1'b0);
      wr(a[7:0], 1'b0);
      for (int i = 0; i < 3; i++) begin
         rd = 8'(rnd());
         expq.push_back({a + 16'(i), rd});
         wr(rd, 1'b0);
      end
      m.stop_cond();
      chk("addr", raddr, a + 16'd3);
      m.start_cond();
      wr(8'hEC, 1'b1); // other sensor
      wr(8'h00, 1'b1);
      m.stop_cond();
      a = 16'(rnd());
      m.start_cond();
      wr(8'hE4, 1'b0);
      wr(a[15:8], 1'b0);
      wr(a[7:0], 1'b0);
      m.start_cond();
      wr(8'hE5, 1'b0); // read
      rdb(a[7:0] ^ 8'h5A, 1'b0);
      rdb(8'(a + 16'd1) ^ 8'h5A, 1'b1);
      m.stop_cond();
      chk("addr", raddr, a + 16'd2);
      @(posedge sys_clk) sel <= 1'b1;
      m.start_cond();
      wr(8'hEC, 1'b0);
      repeat (3) m.put_bit(1'b1, ack);
      m.start_cond();
      wr(8'hED, 1'b0);
      rdb(8'(a + 16'd2) ^ 8'h5A, 1'b1);
      repeat (10) @(posedge sys_clk);
      chk("busy", busy, 1'b0);
      chk("addr", raddr, a + 16'd3);
      chk("queue", 24'(expq.size()), 24'h0);
      final_report();
   end
endmodule
bind sscs_slave sscs_sva chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
   .link_clock_pin(link_clock_pin), .serial_data_pin_in(serial_data_pin_in),
   .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
   .reg_req(reg_req), .reg_addr(reg_addr), .busy(busy));
